/* logic/ceq_defines.svh */
/*
 * Constants of the extended instruction quirk decoder: opcode lengths,
 * program counter shortfall, stack step and reset values.
 * Assumes inclusion by bare name from any file of the block.
 */
`ifndef CEQ_DEFINES_SVH
`define CEQ_DEFINES_SVH

// ****************************************************************
// Opcode lengths in bytes
// ****************************************************************
`define CEQ_LEN_SHORT    3'h2
`define CEQ_LEN_ADDR_IMM 3'h4
`define CEQ_LEN_EXT_IMM  3'h6

// ****************************************************************
// Arithmetic figures
// ****************************************************************
`define CEQ_PC_SHORTFALL 20'h00002
`define CEQ_SP_STEP      20'h00004

// ****************************************************************
// Reset values
// ****************************************************************
`define CEQ_RST_WORD     20'h00000
`define CEQ_RST_LEN      3'h0

`endif

/* logic/ceq_pkg.sv */
/*
 * Types of the extended instruction quirk decoder.
 * Assumes the fetch stage classifies each instruction into these codes.
 */
`default_nettype none

package ceq_pkg;

	// Instruction classes the decoder cares about
	typedef enum logic [3:0] {
		CEQ_OP_OTHER,
		CEQ_OP_ADDRESS_ADD,
		CEQ_OP_ADDRESS_SUBTRACT,
		CEQ_OP_ADDRESS_COMPARE,
		CEQ_OP_EXT_ADD,
		CEQ_OP_EXT_SUBTRACT,
		CEQ_OP_EXT_COMPARE,
		CEQ_OP_EXTENDED_ADDRESS_MOVE,
		CEQ_OP_EXTENDED_ADDRESS_PUSH
	} ceq_op_t;

	// Source addressing modes
	typedef enum logic [2:0] {
		CEQ_MODE_REGISTER,
		CEQ_MODE_INDEXED,
		CEQ_MODE_INDIRECT,
		CEQ_MODE_AUTOINC,
		CEQ_MODE_IMMEDIATE
	} ceq_mode_t;

	// Low-power entry tracking states
	typedef enum logic [1:0] {
		CEQ_TRK_IDLE,
		CEQ_TRK_ARMED,
		CEQ_TRK_PRIMED
	} ceq_trk_t;

endpackage

`default_nettype wire

/* logic/ceq_lpm_track.sv */
/*
 * Tracker of the low-power entry sequence that widens the first
 * non-maskable interrupt handler instruction.
 * Assumes one valid strobe per decoded instruction on sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module ceq_lpm_track (
	input  wire logic            sys_clk,
	input  wire logic            rst_n,
	input  wire logic            quirk_fix,
	input  wire logic            inst_valid,
	input  wire ceq_pkg::ceq_mode_t inst_src_mode,
	input  wire logic            inst_enters_lpm,
	input  wire logic            inst_a20,
	input  wire logic            inst_reg_reg,
	input  wire logic            inst_nop,
	input  wire logic            nmi_pending,
	input  wire logic            nmi_first,
	output logic                 force_wide,
	output logic                 primed
);
	import ceq_pkg::*;

	ceq_trk_t state_reg;   // Sequence position
	ceq_trk_t state_next;  // Next sequence position

	// ****************************************************************
	// Sequence state
	// ****************************************************************

	// State register
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_reg <= CEQ_TRK_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Next state and widening decision
	always_comb begin
		state_next = state_reg;
		force_wide = 1'b0;
		if (inst_valid) begin
			case (state_reg)
				CEQ_TRK_IDLE: begin
					// Indexed entry only counts with an interrupt pending
					if (inst_enters_lpm && inst_src_mode == CEQ_MODE_INDEXED &&
					    nmi_pending && !quirk_fix) begin
						state_next = CEQ_TRK_ARMED;
					end
				end
				CEQ_TRK_ARMED: begin
					// A no-operation here breaks the chain
					if (inst_a20 && inst_reg_reg && !inst_nop) begin
						state_next = CEQ_TRK_PRIMED;
					end else begin
						state_next = CEQ_TRK_IDLE;
					end
				end
				CEQ_TRK_PRIMED: begin
					// First handler word runs wide unless it is a no-op
					// Corrected core never widens, even if it was primed earlier
					force_wide = nmi_first && !inst_nop && !quirk_fix;
					state_next = nmi_first ? CEQ_TRK_IDLE : CEQ_TRK_PRIMED;
				end
				default: begin
					state_next = CEQ_TRK_IDLE;
				end
			endcase
		end
	end

	assign primed = (state_reg == CEQ_TRK_PRIMED);

endmodule

`default_nettype wire

/* logic/ceq_decoder.sv */
/*
 * Extended instruction quirk decoder: opcode length, program counter
 * operand, stack pointer update and forced 20-bit width per instruction.
 * Assumes fetch classifies each instruction and presents it with one
 * valid strobe; all inputs come from logic on sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ceq_defines.svh"

module ceq_decoder (
	input  wire logic               sys_clk,
	input  wire logic               rst_n,
	input  wire logic               quirk_fix,
	input  wire logic               inst_valid,
	input  wire ceq_pkg::ceq_op_t   inst_op,
	input  wire ceq_pkg::ceq_mode_t inst_src_mode,
	input  wire logic               inst_src_sp,
	input  wire logic               inst_dst_pc,
	input  wire logic               inst_reg_reg,
	input  wire logic               inst_a20,
	input  wire logic               inst_nop,
	input  wire logic               inst_enters_lpm,
	input  wire logic [19:0]        inst_pc,
	input  wire logic [19:0]        sp_in,
	input  wire logic [19:0]        sp_mem_word,
	input  wire logic               nmi_pending,
	input  wire logic               nmi_first,
	output logic                    out_valid_reg,
	output logic [2:0]              out_len_reg,
	output logic                    out_width20_reg,
	output logic [19:0]             out_pc_operand_reg,
	output logic                    out_sp_we_reg,
	output logic [19:0]             out_sp_value_reg
);
	import ceq_pkg::*;

	// ****************************************************************
	// Helpers
	// ****************************************************************

	// Opcode length of an instruction
	function automatic logic [2:0] ceq_len(input ceq_op_t op, input ceq_mode_t md);
		logic imm;
		imm = (md == CEQ_MODE_IMMEDIATE);
		case (op)
			CEQ_OP_ADDRESS_ADD, CEQ_OP_ADDRESS_SUBTRACT, CEQ_OP_ADDRESS_COMPARE:
				ceq_len = imm ? `CEQ_LEN_ADDR_IMM : `CEQ_LEN_SHORT;
			CEQ_OP_EXT_ADD, CEQ_OP_EXT_SUBTRACT, CEQ_OP_EXT_COMPARE,
			CEQ_OP_EXTENDED_ADDRESS_MOVE:
				ceq_len = imm ? `CEQ_LEN_EXT_IMM : `CEQ_LEN_ADDR_IMM;
			default:
				ceq_len = `CEQ_LEN_SHORT;
		endcase
	endfunction

	// Address after an opcode of the given length
	function automatic logic [19:0] ceq_pc_plus(input logic [19:0] pc, input logic [2:0] len);
		ceq_pc_plus = pc + {17'h00000, len};
	endfunction

	// True for the short address arithmetic group
	function automatic logic ceq_is_addr(input ceq_op_t op);
		ceq_is_addr = (op == CEQ_OP_ADDRESS_ADD) || (op == CEQ_OP_ADDRESS_SUBTRACT) ||
		              (op == CEQ_OP_ADDRESS_COMPARE);
	endfunction

	// ****************************************************************
	// Decode
	// ****************************************************************

	logic        force_wide;        // Tracker asks for a wide handler word
	logic        primed;            // Tracker saw entry and wide reg-reg word
	logic [2:0]  len_next;          // Opcode length in bytes
	logic [19:0] pc_operand_next;   // PC value seen by the datapath
	logic        sp_we_next;        // Stack pointer is written
	logic [19:0] sp_value_next;     // Value written to stack pointer
	logic        addr_imm_pc;       // Short immediate address op onto PC
	logic        push_sp_inc;       // Push from stack pointer, auto-increment

	// Low-power entry sequence tracker
	ceq_lpm_track u_track (
		.sys_clk         (sys_clk),
		.rst_n           (rst_n),
		.quirk_fix       (quirk_fix),
		.inst_valid      (inst_valid),
		.inst_src_mode   (inst_src_mode),
		.inst_enters_lpm (inst_enters_lpm),
		.inst_a20        (inst_a20),
		.inst_reg_reg    (inst_reg_reg),
		.inst_nop        (inst_nop),
		.nmi_pending     (nmi_pending),
		.nmi_first       (nmi_first),
		.force_wide      (force_wide),
		.primed          (primed)
	);

	// Classification of the two faulty cases
	assign addr_imm_pc = ceq_is_addr(inst_op) && inst_src_mode == CEQ_MODE_IMMEDIATE &&
	                     inst_dst_pc;
	assign push_sp_inc = inst_op == CEQ_OP_EXTENDED_ADDRESS_PUSH && inst_src_sp &&
	                     inst_src_mode == CEQ_MODE_AUTOINC;

	// Length and program counter operand
	always_comb begin
		len_next = ceq_len(inst_op, inst_src_mode);
		// Correct operand is the address of the next instruction
		pc_operand_next = ceq_pc_plus(inst_pc, len_next);
		if (addr_imm_pc && !quirk_fix) begin
			// Only the first opcode word is accounted for
			pc_operand_next = inst_pc + `CEQ_PC_SHORTFALL;
		end
	end

	// Stack pointer update of the address-width push
	always_comb begin
		sp_we_next = inst_op == CEQ_OP_EXTENDED_ADDRESS_PUSH;
		sp_value_next = sp_in - `CEQ_SP_STEP;
		if (push_sp_inc && !quirk_fix) begin
			// Faulty core: stack pointer takes the word it pointed at
			sp_value_next = sp_mem_word;
		end
	end

	// ****************************************************************
	// Output registers
	// ****************************************************************

	// Valid strobe, one cycle behind the request
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			out_valid_reg <= 1'b0;
		end else begin
			out_valid_reg <= inst_valid;
		end
	end

	// Length, width and PC operand; held between instructions
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			out_len_reg        <= `CEQ_RST_LEN;
			out_width20_reg    <= 1'b0;
			out_pc_operand_reg <= `CEQ_RST_WORD;
		end else if (inst_valid) begin
			out_len_reg        <= len_next;
			out_width20_reg    <= (inst_a20 && !inst_nop) || force_wide;
			out_pc_operand_reg <= pc_operand_next;
		end
	end

	// Stack write strobe is a pulse; value held
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			out_sp_we_reg    <= 1'b0;
			out_sp_value_reg <= `CEQ_RST_WORD;
		end else begin
			out_sp_we_reg <= inst_valid && sp_we_next;
			if (inst_valid && sp_we_next) begin
				out_sp_value_reg <= sp_value_next;
			end
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	wide_handler_a: assert property (
		inst_valid && primed && nmi_first && !inst_nop && !quirk_fix |=> out_width20_reg)
		else $error("first handler word not widened");
	nop_narrow_a: assert property (
		inst_valid && inst_nop |=> !out_width20_reg)
		else $error("no-operation widened");
	nop_breaks_a: assert property (
		inst_valid && inst_nop && !primed |=> !primed)
		else $error("no-operation primed the sequence");
	imm_length_a: assert property (
		inst_valid && ceq_is_addr(inst_op) && inst_src_mode == CEQ_MODE_IMMEDIATE
		|=> out_valid_reg && out_len_reg == `CEQ_LEN_ADDR_IMM)
		else $error("immediate address op not four bytes");
	pc_short_a: assert property (
		inst_valid && addr_imm_pc && !quirk_fix
		|=> out_pc_operand_reg == $past(inst_pc) + `CEQ_PC_SHORTFALL)
		else $error("address op PC operand not short by two");
	move_pc_a: assert property (
		inst_valid && inst_op == CEQ_OP_EXTENDED_ADDRESS_MOVE && inst_dst_pc
		|=> out_pc_operand_reg == $past(inst_pc) + {17'h00000,
		(($past(inst_src_mode) == CEQ_MODE_IMMEDIATE) ? `CEQ_LEN_EXT_IMM : `CEQ_LEN_ADDR_IMM)})
		else $error("move PC operand wrong");
	ext_pc_a: assert property (
		inst_valid && inst_op inside {CEQ_OP_EXT_ADD, CEQ_OP_EXT_SUBTRACT,
		CEQ_OP_EXT_COMPARE} && inst_dst_pc
		|=> out_pc_operand_reg == $past(inst_pc) + {17'h00000,
		(($past(inst_src_mode) == CEQ_MODE_IMMEDIATE) ? `CEQ_LEN_EXT_IMM : `CEQ_LEN_ADDR_IMM)})
		else $error("extended op PC operand wrong");
	push_load_a: assert property (
		inst_valid && push_sp_inc && !quirk_fix
		|=> out_sp_we_reg && out_sp_value_reg == $past(sp_mem_word))
		else $error("push did not load addressed word");
	push_fixed_a: assert property (
		inst_valid && inst_op == CEQ_OP_EXTENDED_ADDRESS_PUSH && quirk_fix
		|=> out_sp_we_reg && out_sp_value_reg == $past(sp_in) - `CEQ_SP_STEP)
		else $error("fixed push did not step by four");

	wide_seen_c: cover property (inst_valid && primed && nmi_first ##1 out_width20_reg);
	short_pc_c:  cover property (inst_valid && addr_imm_pc && !quirk_fix);
	push_bad_c:  cover property (inst_valid && push_sp_inc && !quirk_fix);
	push_good_c: cover property (inst_valid && inst_op == CEQ_OP_EXTENDED_ADDRESS_PUSH && quirk_fix);

endmodule

`default_nettype wire

/* sim/cpu_extended_instruction_quirks_bench.sv */
/*
 * Self-checking bench of the extended instruction quirk decoder.
 * Assumes ceq_pkg and ceq_defines.svh compile before this file and
 * that the decoder answers one cycle after each valid instruction.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ceq_defines.svh"

module cpu_extended_instruction_quirks_bench;
	import ceq_pkg::*;

	// ****************************************************************
	// Signals and bookkeeping
	// ****************************************************************
	typedef struct packed {
		logic [2:0]  len;
		logic        w20;
		logic [19:0] pc;
		logic        chk_sp;
		logic [19:0] sp;
	} ceq_exp_t;                         // One queued expectation

	logic        sys_clk = 1'b0;          // 100 MHz clock
	logic        rst_n = 1'b0;            // Sync reset, active low
	logic        quirk_fix = 1'b0;        // Corrected core when high
	logic        inst_valid = 1'b0;       // Instruction strobe
	ceq_op_t     inst_op = CEQ_OP_OTHER;  // Instruction class
	ceq_mode_t   inst_src_mode = CEQ_MODE_REGISTER;
	logic [7:0]  flg = 8'h00;             // Packed one-bit qualifiers
	logic [19:0] inst_pc = 20'h00000;     // Instruction address
	logic [19:0] sp_in = 20'h00000;       // Stack pointer now
	logic [19:0] sp_mem_word = 20'h00000; // Word at stack pointer
	logic        out_valid_reg;
	logic [2:0]  out_len_reg;
	logic        out_width20_reg;
	logic [19:0] out_pc_operand_reg;
	logic        out_sp_we_reg;
	logic [19:0] out_sp_value_reg;
	ceq_exp_t    exp_q[$];                // Notes from driver to monitor
	ceq_exp_t    e;                       // Note being compared
	integer      seed = 32'h2b801d6c;     // Fixed seed for repeatability
	integer      errors = 0;
	integer      samples_checked = 0;

	always #5 sys_clk = ~sys_clk;

	// Flags order: src_sp dst_pc reg_reg a20 nop lpm nmi_pending nmi_first
	ceq_decoder i_ceq_decoder (
		.sys_clk(sys_clk), .rst_n(rst_n), .quirk_fix(quirk_fix),
		.inst_valid(inst_valid), .inst_op(inst_op), .inst_src_mode(inst_src_mode),
		.inst_src_sp(flg[7]), .inst_dst_pc(flg[6]), .inst_reg_reg(flg[5]),
		.inst_a20(flg[4]), .inst_nop(flg[3]), .inst_enters_lpm(flg[2]),
		.inst_pc(inst_pc), .sp_in(sp_in), .sp_mem_word(sp_mem_word),
		.nmi_pending(flg[1]), .nmi_first(flg[0]),
		.out_valid_reg(out_valid_reg), .out_len_reg(out_len_reg),
		.out_width20_reg(out_width20_reg), .out_pc_operand_reg(out_pc_operand_reg),
		.out_sp_we_reg(out_sp_we_reg), .out_sp_value_reg(out_sp_value_reg));

	// ****************************************************************
	// Comparison and closing
	// ****************************************************************
	task automatic check(input string what, input logic [19:0] seen, input logic [19:0] want);
		samples_checked++;
		if (seen !== want) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, want, seen);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Monitor: every answer consumes the oldest note
	always @(posedge sys_clk) begin
		#1;
		if (out_valid_reg === 1'b1) begin
			if (exp_q.size() == 0) begin
				check("unexpected answer", 20'h00001, 20'h00000);
			end else begin
				e = exp_q.pop_front();
				check("length", {17'h0, out_len_reg}, {17'h0, e.len});
				check("pc operand", out_pc_operand_reg, e.pc);
				check("width20", {19'h0, out_width20_reg}, {19'h0, e.w20});
				check("sp write", {19'h0, out_sp_we_reg}, {19'h0, e.chk_sp});
				if (e.chk_sp) check("sp value", out_sp_value_reg, e.sp);
			end
		end
	end

	// Watchdog well beyond the hundred or so cycles the run needs
	initial begin
		#200000;
		errors++;
		end_sim();
	end

	// ****************************************************************
	// Drivers
	// ****************************************************************
	// One instruction; expectation derived from the documented lengths
	task automatic send(input ceq_op_t op, input ceq_mode_t md, input logic [7:0] f,
		input logic w20);
		ceq_exp_t n;
		logic     imm;
		logic     adr;
		inst_pc = 20'($random(seed));
		sp_in = 20'($random(seed));
		sp_mem_word = 20'($random(seed));
		imm = (md == CEQ_MODE_IMMEDIATE);
		adr = op inside {CEQ_OP_ADDRESS_ADD, CEQ_OP_ADDRESS_SUBTRACT, CEQ_OP_ADDRESS_COMPARE};
		if (adr) n.len = imm ? `CEQ_LEN_ADDR_IMM : `CEQ_LEN_SHORT;
		else if (op inside {[CEQ_OP_EXT_ADD:CEQ_OP_EXTENDED_ADDRESS_MOVE]})
			n.len = imm ? `CEQ_LEN_EXT_IMM : `CEQ_LEN_ADDR_IMM;
		else n.len = `CEQ_LEN_SHORT;
		n.pc = inst_pc + {17'h0, n.len};
		if (!quirk_fix && adr && imm && f[6]) n.pc = n.pc - `CEQ_PC_SHORTFALL;
		n.w20 = w20;
		n.chk_sp = (op == CEQ_OP_EXTENDED_ADDRESS_PUSH);
		n.sp = (!quirk_fix && md == CEQ_MODE_AUTOINC && f[7]) ? sp_mem_word
			: sp_in - `CEQ_SP_STEP;
		exp_q.push_back(n);
		inst_valid = 1'b1;
		inst_op = op;
		inst_src_mode = md;
		flg = f;
		@(posedge sys_clk);
		#1;
	endtask

	task automatic idle(input int n);
		inst_valid = 1'b0;
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic do_reset();
		rst_n = 1'b0;
		inst_valid = 1'b0;
		repeat (5) @(posedge sys_clk);
		#1;
		check("reset valid", {19'h0, out_valid_reg}, 20'h0);
		check("reset pc", out_pc_operand_reg, `CEQ_RST_WORD);
		rst_n = 1'b1;
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial begin
		do_reset();
		$display("test reset done");
		// Address ops, both cores, immediate and register, back to back
		for (int fx = 0; fx < 2; fx++) begin
			quirk_fix = fx[0];
			for (int k = 1; k < 4; k++) begin
				send(ceq_op_t'(k), CEQ_MODE_IMMEDIATE, 8'h40, 1'b0);
				send(ceq_op_t'(k), CEQ_MODE_REGISTER, 8'h40, 1'b0);
			end
		end
		quirk_fix = 1'b0;
		// Extended forms and move keep the correct pc on the faulty core
		for (int k = 4; k < 8; k++) send(ceq_op_t'(k), CEQ_MODE_IMMEDIATE, 8'h50, 1'b1);
		idle(2);
		$display("test program counter done");
		// Push auto-increment from stack pointer, then from another register, faulty then fixed core
		for (int fx = 0; fx < 2; fx++) begin
			quirk_fix = fx[0];
			send(CEQ_OP_EXTENDED_ADDRESS_PUSH, CEQ_MODE_AUTOINC, 8'h90, 1'b1);
			send(CEQ_OP_EXTENDED_ADDRESS_PUSH, CEQ_MODE_AUTOINC, 8'h10, 1'b1);
		end
		idle(2);
		$display("test push done");
		// Widening: plain, nop second, nop in handler, fixed core
		for (int c = 0; c < 4; c++) begin
			do_reset();
			quirk_fix = (c == 3);
			send(CEQ_OP_OTHER, CEQ_MODE_INDEXED, 8'h06, 1'b0);
			if (c == 0) idle(1);
			if (c == 1) send(CEQ_OP_OTHER, CEQ_MODE_REGISTER, 8'h08, 1'b0);
			else send(CEQ_OP_EXTENDED_ADDRESS_MOVE, CEQ_MODE_REGISTER, 8'h30, 1'b1);
			send(CEQ_OP_OTHER, CEQ_MODE_INDEXED, (c == 2) ? 8'h09 : 8'h01, c == 0);
			idle(2);
		end
		quirk_fix = 1'b0;
		$display("test widening done");
		// Random classified instructions outside any entry sequence
		for (int i = 0; i < 40; i++) begin
			logic [7:0] rf;
			rf = 8'($random(seed)) & 8'hf8;
			send(ceq_op_t'($unsigned($random(seed)) % 9), ceq_mode_t'($unsigned($random(seed)) % 5),
				rf, rf[4] & ~rf[3]);
		end
		idle(3);
		check("queue left", 20'(exp_q.size()), 20'h0);
		$display("test random done");
		end_sim();
	end

endmodule
`default_nettype wire
